// file: hdl/exs_pkg.sv
// package of the exception status block: map, fields, types
// assumes one AHB-Lite master and one processor core beside it
package exs_pkg;

	// ***********************************
	// register indices, byte address = 4 x index
	// ***********************************
	localparam logic [31:0] EXS_HI_IDX = 32'h00ffe020;
	localparam logic [31:0] EXS_LO_IDX = 32'h00ffe021;
	localparam logic [31:0] EXS_LAST_IDX = 32'h00ffe023;
	localparam logic [31:0] EXS_PAIR_IDX = 32'h00ffe028;
	localparam logic [31:0] EXS_MASK_IDX = 32'h00ffe029;
	localparam logic [31:0] EXS_HI_ADDR = EXS_HI_IDX << 2;
	localparam logic [31:0] EXS_LO_ADDR = EXS_LO_IDX << 2;
	localparam logic [31:0] EXS_LAST_ADDR = EXS_LAST_IDX << 2;
	localparam logic [31:0] EXS_PAIR_ADDR = EXS_PAIR_IDX << 2;
	localparam logic [31:0] EXS_MASK_ADDR = EXS_MASK_IDX << 2;

	// ***********************************
	// field positions and reset values
	// ***********************************
	localparam int EXS_HI_LSB = 3;
	localparam int EXS_LO_MSB = 2;
	localparam int EXS_PAIR_HI_LSB = 11;
	localparam int EXS_VEC_MSB = 6;
	localparam int EXS_VEC_LSB = 2;
	localparam logic [7:0] EXS_FLAGS_RST = 8'h00;
	localparam logic [7:0] EXS_MASK_RST = 8'h00;
	localparam logic [7:0] EXS_LAST_RST = 8'h04;
	localparam logic [23:0] EXS_SYS_VECTOR = 24'h000008;

	// one bit per exception source, high byte sources first
	typedef struct packed {
		logic stack_overflow_flag;
		logic pc_overflow_flag;
		logic zero_divisor_flag;
		logic quotient_overflow_flag;
		logic bad_opcode_flag;
		logic watchdog_osc_fail_flag;
		logic main_osc_fail_flag;
		logic watchdog_exception_flag;
	} exs_flags_t;

	// serviced interrupt report from the core
	typedef struct packed {
		logic serviced;
		logic [23:0] vector;
	} exs_service_t;

	typedef enum logic [2:0] {
		SEL_NONE = 3'b000,
		SEL_HI = 3'b001,
		SEL_LO = 3'b010,
		SEL_LAST = 3'b011,
		SEL_PAIR = 3'b100,
		SEL_MASK = 3'b101
	} exs_sel_t;

endpackage

// file: hdl/exs_top.sv
// exception status flags, last serviced vector, AHB-Lite slave
// assumes core event pulses synchronous to ref_clk_i
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module exs_top
	import exs_pkg::*;
(
	input wire logic ref_clk_i, // 250 MHz system clock
	input wire logic resetn_i, // sync reset, active low
	input wire logic hsel_i, // slave select
	input wire logic [31:0] haddr_i, // byte address
	input wire logic [1:0] htrans_i, // transfer type
	input wire logic hwrite_i, // write when high
	input wire logic [2:0] hsize_i, // word only
	input wire logic [31:0] hwdata_i, // write data
	input wire logic hready_i, // bus ready in
	input wire exs_flags_t exc_event_i, // exception pulses
	input wire exs_service_t service_i, // serviced interrupt
	output logic [31:0] hrdata_o, // read data
	output logic hreadyout_o, // slave ready
	output logic hresp_o, // always okay
	output logic exc_req_o, // new exception pulse
	output logic [23:0] exc_vector_o, // shared vector
	output logic irq_o // unmasked flag pending
);

	// ***********************************
	// state
	// ***********************************
	exs_flags_t flags;
	exs_flags_t next_flags;
	logic [7:0] mask;
	logic [7:0] next_mask;
	logic [7:0] last;
	logic [7:0] next_last;
	exs_sel_t wr_sel;
	exs_sel_t next_wr_sel;
	logic [31:0] next_hrdata;
	logic next_exc_req;
	logic next_irq;
	logic [7:0] clr;
	logic [7:0] accept;
	logic addr_ok;
	exs_sel_t addr_sel;

	// ***********************************
	// address phase decode
	// ***********************************
	always_comb begin
		addr_ok = hsel_i && htrans_i[1] && hready_i;
		addr_sel = SEL_NONE;
		if (addr_ok) begin
			if (haddr_i == EXS_HI_ADDR) begin
				addr_sel = SEL_HI;
			end else if (haddr_i == EXS_LO_ADDR) begin
				addr_sel = SEL_LO;
			end else if (haddr_i == EXS_LAST_ADDR) begin
				addr_sel = SEL_LAST;
			end else if (haddr_i == EXS_PAIR_ADDR) begin
				addr_sel = SEL_PAIR;
			end else if (haddr_i == EXS_MASK_ADDR) begin
				addr_sel = SEL_MASK;
			end
		end
	end

	// ***********************************
	// flags, mask, last vector
	// ***********************************
	always_comb begin
		clr = 8'h00;
		next_mask = mask;
		next_last = last;
		// write lands in the data phase, hwdata valid now
		unique case (wr_sel)
			SEL_NONE: begin
			end
			SEL_HI: begin
				clr[7:EXS_HI_LSB] = hwdata_i[7:EXS_HI_LSB];
			end
			SEL_LO: begin
				clr[EXS_LO_MSB:0] = hwdata_i[EXS_LO_MSB:0];
			end
			SEL_PAIR: begin
				clr[7:EXS_HI_LSB] = hwdata_i[15:EXS_PAIR_HI_LSB];
				clr[EXS_LO_MSB:0] = hwdata_i[EXS_LO_MSB:0];
			end
			SEL_MASK: begin
				next_mask[7:EXS_HI_LSB] = hwdata_i[15:EXS_PAIR_HI_LSB];
				next_mask[EXS_LO_MSB:0] = hwdata_i[EXS_LO_MSB:0];
			end
			SEL_LAST: begin
				next_last[EXS_VEC_MSB:EXS_VEC_LSB] =
					hwdata_i[EXS_VEC_MSB:EXS_VEC_LSB];
			end
			default: begin
			end
		endcase
		// core report beats a software write in the same cycle
		if (service_i.serviced) begin
			next_last[EXS_VEC_MSB:EXS_VEC_LSB] =
				service_i.vector[EXS_VEC_MSB:EXS_VEC_LSB];
		end
		next_last[7] = 1'b0;
		next_last[1:0] = 2'b00;
		// a source already flagged raises nothing new
		accept = exc_event_i & ~flags;
		// set after clear so a same-cycle event survives
		next_flags = (flags & ~clr) | exc_event_i;
		// no global enable term: a pulse from any source not yet flagged always goes out
		next_exc_req = |accept;
		next_irq = |(next_flags & next_mask);
	end

	// bit mapping of each source, for the record:
	// high byte 7..3
	// low byte 2..0

	// ***********************************
	// read data, taken from next values
	// ***********************************
	// next values avoid a stale read right after a write
	always_comb begin
		next_hrdata = 32'h0000_0000;
		next_wr_sel = SEL_NONE;
		if (addr_ok && hwrite_i) begin
			next_wr_sel = addr_sel;
		end
		if (addr_ok && !hwrite_i) begin
			unique case (addr_sel)
				SEL_NONE: begin
				end
				SEL_HI: begin
					next_hrdata[7:EXS_HI_LSB] =
						next_flags[7:EXS_HI_LSB];
				end
				SEL_LO: begin
					next_hrdata[EXS_LO_MSB:0] =
						next_flags[EXS_LO_MSB:0];
				end
				SEL_PAIR: begin
					next_hrdata[15:EXS_PAIR_HI_LSB] =
						next_flags[7:EXS_HI_LSB];
					next_hrdata[EXS_LO_MSB:0] = next_flags[EXS_LO_MSB:0];
				end
				SEL_MASK: begin
					next_hrdata[15:EXS_PAIR_HI_LSB] = next_mask[7:EXS_HI_LSB];
					next_hrdata[EXS_LO_MSB:0] = next_mask[EXS_LO_MSB:0];
				end
				SEL_LAST: begin
					next_hrdata[7:0] = next_last;
				end
				default: begin
				end
			endcase
		end
	end

	// ***********************************
	// registers
	// ***********************************
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			flags <= EXS_FLAGS_RST;
			mask <= EXS_MASK_RST;
			last <= EXS_LAST_RST;
			wr_sel <= SEL_NONE;
			hrdata_o <= 32'h0000_0000;
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
			exc_req_o <= 1'b0;
			exc_vector_o <= EXS_SYS_VECTOR;
			irq_o <= 1'b0;
		end else begin
			flags <= next_flags;
			mask <= next_mask;
			last <= next_last;
			wr_sel <= next_wr_sel;
			hrdata_o <= next_hrdata;
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
			exc_req_o <= next_exc_req;
			exc_vector_o <= EXS_SYS_VECTOR;
			irq_o <= next_irq;
		end
	end

	// ***********************************
	// assertions
	// ***********************************
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!resetn_i);

	property p_stack_overflow_flag;
		exc_event_i.stack_overflow_flag |=> flags.stack_overflow_flag;
	endproperty
	a_stack_overflow_flag: assert property (p_stack_overflow_flag)
		else $error("stack overflow flag not set");

	property p_pc_overflow_flag;
		exc_event_i.pc_overflow_flag |=> flags.pc_overflow_flag;
	endproperty
	a_pc_overflow_flag: assert property (p_pc_overflow_flag)
		else $error("pc overflow flag not set");

	property p_zero_divisor_flag;
		exc_event_i.zero_divisor_flag |=> flags.zero_divisor_flag;
	endproperty
	a_zero_divisor_flag: assert property (p_zero_divisor_flag)
		else $error("zero divisor flag not set");

	property p_quotient_overflow_flag;
		exc_event_i.quotient_overflow_flag
			|=> flags.quotient_overflow_flag;
	endproperty
	a_quotient_overflow_flag: assert property (p_quotient_overflow_flag)
		else $error("quotient overflow flag not set");

	property p_ill;
		exc_event_i.bad_opcode_flag |=> flags.bad_opcode_flag;
	endproperty
	a_ill: assert property (p_ill)
		else $error("bad opcode flag not set");

	property p_lowsrc;
		exc_event_i[2:0] != 3'h0
			|=> (flags[2:0] & $past(exc_event_i[2:0])) ==
				$past(exc_event_i[2:0]);
	endproperty
	a_lowsrc: assert property (p_lowsrc)
		else $error("low byte flag not set");

	property p_fall;
		$fell(|flags) |-> $past(wr_sel) != SEL_NONE;
	endproperty
	a_fall: assert property (p_fall)
		else $error("flag cleared without a write");

	property p_hold;
		(wr_sel == SEL_NONE) |=> ((flags & $past(flags)) == $past(flags));
	endproperty
	a_hold: assert property (p_hold)
		else $error("flag lost without a clearing write");

	property p_block;
		((exc_event_i & ~flags) == 8'h00) |=> !exc_req_o;
	endproperty
	a_block: assert property (p_block)
		else $error("request from a blocked source");

	property p_req;
		((exc_event_i & ~flags) != 8'h00)
			|=> exc_req_o && exc_vector_o == EXS_SYS_VECTOR;
	endproperty
	a_req: assert property (p_req)
		else $error("exception request missing");

	property p_last;
		service_i.serviced |=> last[6:2] == $past(service_i.vector[6:2]);
	endproperty
	a_last: assert property (p_last)
		else $error("serviced vector not stored");

	property p_zero;
		last[7] == 1'b0 && last[1:0] == 2'b00;
	endproperty
	a_zero: assert property (p_zero)
		else $error("fixed bits of last vector not zero");

	property p_pair;
		addr_ok && !hwrite_i && addr_sel == SEL_PAIR
			|=> hrdata_o[15:11] == flags[7:3]
				&& hrdata_o[2:0] == flags[2:0];
	endproperty
	a_pair: assert property (p_pair)
		else $error("16-bit read mismatch");

	c_exc: cover property ((exc_event_i != 8'h00) && (accept == 8'h00));
	c_race: cover property ((wr_sel == SEL_HI) && exc_event_i[7]);
	c_serv: cover property (service_i.serviced ##1 (last != EXS_LAST_RST));

endmodule

`default_nettype wire

// file: testbench/exs_core_model.sv
// core model: exception pulses and serviced interrupt reports
// assumes one bench thread calls its tasks, clock from the bench
`timescale 1ns/1ps
`default_nettype none

module exs_core_model
	import exs_pkg::*;
(
	input wire logic ref_clk_i, // system clock
	output var exs_flags_t exc_event_o, // exception pulses
	output var exs_service_t service_o // serviced interrupt
);
	initial begin
		exc_event_o = '0;
		service_o = '0;
	end

	// ***********************************
	// core side tasks
	// ***********************************
	// one-cycle pulse, several sources may share it
	task automatic raise(input exs_flags_t ev);
		@(posedge ref_clk_i);
		exc_event_o <= ev;
		@(posedge ref_clk_i);
		exc_event_o <= '0;
	endtask

	// vector inverted afterwards so a late sample shows up
	task automatic serve(input logic [23:0] vec);
		@(posedge ref_clk_i);
		service_o <= {1'b1, vec};
		@(posedge ref_clk_i);
		service_o <= {1'b0, ~vec};
	endtask
endmodule

`default_nettype wire

// file: testbench/tb_top.sv
// bench for the exception status block over AHB-Lite
// assumes zero-wait slave; core side played by exs_core_model
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import exs_pkg::*;
	logic ref_clk_i, resetn_i, hsel_i, hwrite_i;
	logic [1:0] htrans_i;
	logic [2:0] hsize_i;
	logic [31:0] haddr_i, hwdata_i, hrdata_o, a;
	logic hreadyout_o, hresp_o, exc_req_o, irq_o;
	logic [23:0] exc_vector_o;
	logic [23:0] vecs [4] = '{24'h000030, 24'h00006c, 24'h0000ff, 24'hfffff8};
	exs_flags_t ev;
	exs_service_t sv;
	int n_mismatch = 0, cmp_count = 0, n_req = 0, cyc = 0;

	exs_core_model i_core (.ref_clk_i(ref_clk_i), .exc_event_o(ev),
		.service_o(sv));
	exs_top i_dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
		.hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
		.hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
		.hready_i(hreadyout_o), .exc_event_i(ev), .service_i(sv),
		.hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
		.exc_req_o(exc_req_o), .exc_vector_o(exc_vector_o), .irq_o(irq_o));

	initial begin
		ref_clk_i = 1'b0;
		forever #2 ref_clk_i = ~ref_clk_i;
	end

	// ***********************************
	// checks and bus tasks
	// ***********************************
	task automatic results();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (cmp_count > 0 && n_mismatch == 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic bus(input logic w, input logic [31:0] ad, d,
		output logic [31:0] q);
		@(posedge ref_clk_i);
		hsel_i <= 1'b1;
		haddr_i <= ad;
		htrans_i <= 2'b10;
		hwrite_i <= w;
		do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
		htrans_i <= 2'b00;
		hwdata_i <= d;
		do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
		q = hrdata_o;
		chk("hresp", 32'h0, {31'h0, hresp_o});
	endtask

	task automatic wr(input logic [31:0] ad, d);
		logic [31:0] q;
		bus(1'b1, ad, d, q);
	endtask

	task automatic rdc(input string nm, input logic [31:0] ad, e);
		logic [31:0] q;
		bus(1'b0, ad, 32'h0, q);
		chk(nm, e, q);
	endtask

	// pulses counted here, the design gives no other tally
	always @(posedge ref_clk_i) begin
		cyc++;
		if (exc_req_o === 1'b1)
			n_req++;
		if (cyc == 20000) begin
			n_mismatch++;
			results();
		end
	end

	// ***********************************
	// test sequence
	// ***********************************
	initial begin
		resetn_i = 1'b0;
		hsel_i = 1'b0;
		haddr_i = 32'h0;
		htrans_i = 2'b00;
		hwrite_i = 1'b0;
		hsize_i = 3'b010;
		hwdata_i = 32'h0;
		repeat (4) @(posedge ref_clk_i);
		resetn_i <= 1'b1;
		rdc("hi", EXS_HI_ADDR, 32'h0);
		rdc("lo", EXS_LO_ADDR, 32'h0);
		rdc("last", EXS_LAST_ADDR, 32'h04);
		rdc("mask", EXS_MASK_ADDR, 32'h0);
		for (int i = 0; i < 8; i++) begin
			a = (i >= 3) ? EXS_HI_ADDR : EXS_LO_ADDR;
			i_core.raise(exs_flags_t'(8'h01 << i));
			i_core.raise(exs_flags_t'(8'h01 << i));
			rdc("flag", a, 32'h1 << i);
			chk("req", i + 1, n_req);
			wr(a, 32'h0);
			rdc("keep", a, 32'h1 << i);
			wr(a, 32'h1 << i);
			rdc("clr", a, 32'h0);
			chk("irq", 32'h0, {31'h0, irq_o});
		end
		chk("vec", 32'h000008, {8'h00, exc_vector_o});
		fork
			wr(EXS_HI_ADDR, 32'h80);
			begin
				@(posedge ref_clk_i);
				i_core.raise(exs_flags_t'(8'h80));
			end
		join
		rdc("race", EXS_HI_ADDR, 32'h80);
		i_core.raise(exs_flags_t'(8'h09));
		rdc("pair", EXS_PAIR_ADDR, 32'h8801);
		chk("req2", 32'd10, n_req);
		wr(EXS_MASK_ADDR, 32'h0800);
		rdc("mask", EXS_MASK_ADDR, 32'h0800);
		chk("irq1", 32'h1, {31'h0, irq_o});
		wr(EXS_PAIR_ADDR, 32'h0801);
		rdc("pair", EXS_PAIR_ADDR, 32'h8000);
		chk("irq0", 32'h0, {31'h0, irq_o});
		wr(EXS_HI_ADDR, 32'h80);
		rdc("hi", EXS_HI_ADDR, 32'h0);
		for (int i = 0; i < 4; i++) begin
			i_core.serve(vecs[i]);
			rdc("last", EXS_LAST_ADDR, {8'h0, vecs[i] & 24'h7c});
		end
		wr(EXS_LAST_ADDR, 32'hff);
		rdc("lastw", EXS_LAST_ADDR, 32'h7c);
		// unmapped place: reads zero, write lands nowhere
		wr(32'h0, 32'hff);
		rdc("unmap", 32'h0, 32'h0);
		rdc("hi", EXS_HI_ADDR, 32'h0);
		results();
	end
endmodule

`default_nettype wire
